/* File: pacl_defines.svh */
`ifndef PACL_DEFINES_SVH
`define PACL_DEFINES_SVH

// clock
`define PACL_CLK_NS 100

// device timing, time then cycles
`define PACL_T_POR_MIN_MS 12
`define PACL_POR_CYC ((`PACL_T_POR_MIN_MS * 1000000 + `PACL_CLK_NS - 1) / `PACL_CLK_NS)
`define PACL_T_STATUS_MIN_US 10
`define PACL_STATUS_MIN_CYC ((`PACL_T_STATUS_MIN_US * 1000 + `PACL_CLK_NS - 1) / `PACL_CLK_NS)
`define PACL_T_CD2UM_MIN_US 20
`define PACL_CD2UM_CYC ((`PACL_T_CD2UM_MIN_US * 1000 + `PACL_CLK_NS - 1) / `PACL_CLK_NS)
`define PACL_USER_CLK_EDGES 299
`define PACL_T_BUSY_MIN_NS 7
`define PACL_BUSY_CYC ((`PACL_T_BUSY_MIN_NS + `PACL_CLK_NS - 1) / `PACL_CLK_NS)

// host timing, time then cycles
`define PACL_T_CFG_MIN_US 2
`define PACL_CFG_CYC ((`PACL_T_CFG_MIN_US * 1000 + `PACL_CLK_NS - 1) / `PACL_CLK_NS)
`define PACL_T_CF2WS_MIN_US 100
`define PACL_CF2WS_CYC ((`PACL_T_CF2WS_MIN_US * 1000 + `PACL_CLK_NS - 1) / `PACL_CLK_NS)
`define PACL_T_CD2CU_MIN_NS 40
`define PACL_CD2CU_CYC ((`PACL_T_CD2CU_MIN_NS + `PACL_CLK_NS - 1) / `PACL_CLK_NS)
`define PACL_SETTLE_CYC 6
`define PACL_UCLK_HALF_CYC 2

// widths
`define PACL_CNT_W 17
`define PACL_SMALL_W 4

// device sync vector bit positions
`define PACL_SY_RECONF 0
`define PACL_SY_WS 1
`define PACL_SY_RS 2
`define PACL_SY_NCS 3
`define PACL_SY_CS 4
`define PACL_SY_STAT 5
`define PACL_SY_UCLK 6
`define PACL_SY_W 7

// host sync vector bit positions
`define PACL_HY_STAT 0
`define PACL_HY_DONE 1
`define PACL_HY_RDY 2
`define PACL_HY_D7 3
`define PACL_HY_W 4

// data bus
`define PACL_D7 7

`endif

/* File: pacl_device.sv */
// How it works
// - user mode: lines high; request low restarts
// - status held low for power-on delay
// - done low until configuration completes
// - request low pulls done, status low
// - host holds request low two microseconds
// - status low pulse ten to hundred microseconds
// - status released soon after request rises
// - host waits before first write strobe
// - byte and select taken at strobe rise
// - host may toggle selects between bytes
// - busy driven low after each strobe
// - busy low pulse is bounded; busy also held low while the receive buffer is full
// - host waits after ready before strobe
// - host read strobe spaced from write
// - bit seven shows ready while read strobed
// - internal clock startup twenty to forty microseconds
// - user clock: 299 periods into user mode
// - pins become user I/O after configuration
// - only active device drives bit seven
// - chain enable out low when finished
`timescale 1ns/1ps
`include "pacl_defines.svh"
module pacl_device #(
  parameter int unsigned POR_CYC = `PACL_POR_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // link
  pacl_link_if.device link,
  // user control
  input wire logic chain_enable_in_n,
  input wire logic image_complete,
  input wire logic use_user_clock,
  output logic user_mode,
  // received bytes
  output logic out_valid,
  output pacl_pkg::pacl_byte_type out_data,
  input wire logic out_ready
);
  import pacl_pkg::*;

  // synchronisers
  logic [`PACL_SY_W-1:0] sy1_reg;
  logic [`PACL_SY_W-1:0] sy2_reg;
  pacl_byte_type d1_reg;
  pacl_byte_type d2_reg;
  logic ws_prev_reg;
  logic uc_prev_reg;
  wire logic [`PACL_SY_W-1:0] sy_raw;

  assign sy_raw = {link.user_startup_clock, link.status_n, link.chip_select, link.select_low_active,
                   link.read_strobe_n, link.write_strobe_n, link.reconfig_n};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sy1_reg <= 7'h7f;
      sy2_reg <= 7'h7f;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
      ws_prev_reg <= 1'b1;
      uc_prev_reg <= 1'b1;
    end else begin
      sy1_reg <= sy_raw;
      sy2_reg <= sy1_reg;
      d1_reg <= link.data;
      d2_reg <= d1_reg;
      ws_prev_reg <= sy2_reg[`PACL_SY_WS];
      uc_prev_reg <= sy2_reg[`PACL_SY_UCLK];
    end
  end

  // decoded link conditions
  wire logic reconfig_low;
  wire logic ws_rise;
  wire logic selected;
  wire logic status_high;
  wire logic uclk_rise;
  wire logic rs_low;
  assign reconfig_low = !sy2_reg[`PACL_SY_RECONF];
  assign ws_rise = sy2_reg[`PACL_SY_WS] & !ws_prev_reg;
  assign selected = sy2_reg[`PACL_SY_CS] & !sy2_reg[`PACL_SY_NCS];
  assign status_high = sy2_reg[`PACL_SY_STAT];
  assign uclk_rise = sy2_reg[`PACL_SY_UCLK] & !uc_prev_reg;
  assign rs_low = !sy2_reg[`PACL_SY_RS];

  // sequencer
  pacl_dev_state_type state_reg;
  pacl_dev_state_type state_next;
  logic [`PACL_CNT_W-1:0] cnt_reg;
  logic [`PACL_CNT_W-1:0] cnt_next;
  logic done_reg;
  wire logic [`PACL_CNT_W-1:0] cnt_inc;
  wire logic por_end;
  wire logic status_min_met;
  wire logic startup_end;
  assign cnt_inc = cnt_reg + 17'h0_0001;
  assign por_end = (cnt_reg == `PACL_CNT_W'(POR_CYC - 1));
  assign status_min_met = (cnt_reg >= `PACL_CNT_W'(`PACL_STATUS_MIN_CYC - 1));
  assign startup_end = use_user_clock ?
                       (uclk_rise && cnt_reg == `PACL_CNT_W'(`PACL_USER_CLK_EDGES - 1)) :
                       (cnt_reg == `PACL_CNT_W'(`PACL_CD2UM_CYC - 1));

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_inc;
    case (state_reg)
      DEV_POR: begin
        if (por_end) begin
          state_next = DEV_WAIT;
          cnt_next = '0;
        end
      end
      DEV_CLEAR: begin
        if (status_min_met) begin
          cnt_next = cnt_reg;
          if (!reconfig_low) begin
            state_next = DEV_WAIT;
          end
        end
      end
      DEV_WAIT: begin
        cnt_next = '0;
        if (status_high) begin
          state_next = DEV_CONFIG;
        end
      end
      DEV_CONFIG: begin
        cnt_next = '0;
        if (image_complete) begin
          state_next = DEV_STARTUP;
        end
      end
      DEV_STARTUP: begin
        if (use_user_clock && !uclk_rise) begin
          cnt_next = cnt_reg;
        end
        if (startup_end) begin
          state_next = DEV_USER;
          cnt_next = '0;
        end
      end
      DEV_USER: begin
        cnt_next = cnt_reg;
      end
      default: begin
        state_next = DEV_POR;
        cnt_next = '0;
      end
    endcase
    if (reconfig_low && state_reg != DEV_POR) begin
      state_next = DEV_CLEAR;
      if (state_reg != DEV_CLEAR) begin
        cnt_next = '0;
      end
    end
  end

  // two-entry receive buffer
  logic head_v_reg;
  logic spare_v_reg;
  pacl_byte_type head_d_reg;
  pacl_byte_type spare_d_reg;
  logic head_v_next;
  logic spare_v_next;
  pacl_byte_type head_d_next;
  pacl_byte_type spare_d_next;
  wire logic take;
  wire logic push;
  wire logic pop;
  wire logic full_next;
  assign take = ws_rise & selected & (state_reg == DEV_CONFIG) & status_high & !done_reg;
  assign push = take & !(head_v_reg & spare_v_reg);
  assign pop = head_v_reg & out_ready;

  always_comb begin
    head_v_next = head_v_reg;
    head_d_next = head_d_reg;
    spare_v_next = spare_v_reg;
    spare_d_next = spare_d_reg;
    if (pop || !head_v_reg) begin
      if (spare_v_reg) begin
        head_v_next = 1'b1;
        head_d_next = spare_d_reg;
        spare_v_next = push;
        spare_d_next = push ? d2_reg : spare_d_reg;
      end else begin
        head_v_next = push;
        head_d_next = push ? d2_reg : head_d_reg;
      end
    end else if (push) begin
      spare_v_next = 1'b1;
      spare_d_next = d2_reg;
    end
    if (reconfig_low) begin
      head_v_next = 1'b0;
      spare_v_next = 1'b0;
    end
  end
  assign full_next = head_v_next & spare_v_next;

  // busy pulse
  logic [`PACL_SMALL_W-1:0] busy_cnt_reg;
  wire logic [`PACL_SMALL_W-1:0] busy_cnt_next;
  assign busy_cnt_next = take ? `PACL_SMALL_W'(`PACL_BUSY_CYC) :
                         (busy_cnt_reg != '0 ? busy_cnt_reg - 4'h1 : busy_cnt_reg);

  // pin decode
  wire logic status_pull;
  wire logic configured;
  wire logic d7_drive;
  assign status_pull = (state_next == DEV_POR) || (state_next == DEV_CLEAR);
  assign configured = (state_next == DEV_STARTUP) || (state_next == DEV_USER);
  assign d7_drive = (state_next == DEV_CONFIG) && !chain_enable_in_n && rs_low;

  logic status_oe_n_reg;
  logic status_out_reg;
  logic ceo_n_reg;
  logic rdy_reg;
  logic d7_oe_n_reg;
  logic d7_out_reg;
  logic user_mode_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DEV_POR;
      cnt_reg <= '0;
      head_v_reg <= 1'b0;
      spare_v_reg <= 1'b0;
      head_d_reg <= 8'h00;
      spare_d_reg <= 8'h00;
      busy_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      head_v_reg <= head_v_next;
      spare_v_reg <= spare_v_next;
      head_d_reg <= head_d_next;
      spare_d_reg <= spare_d_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_oe_n_reg <= 1'b0;
      status_out_reg <= 1'b0;
      done_reg <= 1'b0;
      ceo_n_reg <= 1'b1;
      rdy_reg <= 1'b1;
      d7_oe_n_reg <= 1'b1;
      d7_out_reg <= 1'b1;
      user_mode_reg <= 1'b0;
    end else begin
      status_oe_n_reg <= !status_pull;
      status_out_reg <= 1'b0;
      done_reg <= configured;
      ceo_n_reg <= !configured;
      rdy_reg <= !(busy_cnt_next != '0 || full_next);
      d7_oe_n_reg <= !d7_drive;
      d7_out_reg <= rdy_reg;
      user_mode_reg <= (state_next == DEV_USER);
    end
  end

  // outputs
  assign link.dev_status_oe_n = status_oe_n_reg;
  assign link.dev_status_out = status_out_reg;
  assign link.done = done_reg;
  assign link.chain_enable_out_n = ceo_n_reg;
  assign link.ready_busy_flag = rdy_reg;
  assign link.dev_d7_oe_n = d7_oe_n_reg;
  assign link.dev_d7_out = d7_out_reg;
  assign user_mode = user_mode_reg;
  assign out_valid = head_v_reg;
  assign out_data = head_d_reg;
endmodule : pacl_device

/* File: pacl_host.sv */
`timescale 1ns/1ps
`include "pacl_defines.svh"
module pacl_host (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // link
  pacl_link_if.host link,
  // user control
  input wire logic cfg_start,
  input wire logic use_poll,
  input wire logic use_user_clock,
  input wire logic stretch_status,
  output logic cfg_done,
  // bytes to send
  input wire logic in_valid,
  input wire pacl_pkg::pacl_byte_type in_data,
  output logic in_ready
);
  import pacl_pkg::*;

  // synchronisers
  logic [`PACL_HY_W-1:0] hy1_reg;
  logic [`PACL_HY_W-1:0] hy2_reg;
  wire logic [`PACL_HY_W-1:0] hy_raw;
  assign hy_raw = {link.data[`PACL_D7], link.ready_busy_flag, link.done, link.status_n};

  wire logic st_high;
  wire logic done_seen;
  wire logic ready_bit;
  assign st_high = hy2_reg[`PACL_HY_STAT];
  assign done_seen = hy2_reg[`PACL_HY_DONE];
  assign ready_bit = use_poll ? hy2_reg[`PACL_HY_D7] : hy2_reg[`PACL_HY_RDY];

  pacl_host_state_type state_reg;
  pacl_host_state_type state_next;
  logic [`PACL_CNT_W-1:0] cnt_reg;
  logic [`PACL_CNT_W-1:0] cnt_next;
  logic in_ready_reg;
  wire logic take;
  assign take = in_valid & in_ready_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 17'h0_0001;
    case (state_reg)
      H_IDLE: begin
        cnt_next = '0;
        if (cfg_start) begin
          state_next = H_PULSE;
        end
      end
      H_PULSE: begin
        if (cnt_reg == `PACL_CNT_W'(`PACL_CFG_CYC - 1)) begin
          state_next = H_WAITST;
        end
      end
      H_WAITST: begin
        cnt_next = '0;
        if (st_high) begin
          state_next = H_HOLDOFF;
        end
      end
      H_HOLDOFF: begin
        if (cnt_reg == `PACL_CNT_W'(`PACL_CF2WS_CYC - 1)) begin
          state_next = H_READY;
        end
      end
      H_READY: begin
        cnt_next = '0;
        if (done_seen) begin
          state_next = H_IDLE;
        end else if (take) begin
          state_next = H_STROBE;
        end
      end
      H_STROBE: begin
        state_next = H_RISE;
      end
      H_RISE: begin
        cnt_next = '0;
        state_next = H_PACE;
      end
      H_PACE: begin
        if (cnt_reg >= `PACL_CNT_W'(`PACL_SETTLE_CYC - 1)) begin
          cnt_next = cnt_reg;
          if (ready_bit) begin
            state_next = H_READY;
          end
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
    if (cfg_start && (state_reg == H_READY || state_reg == H_HOLDOFF)) begin
      state_next = H_PULSE;
      cnt_next = '0;
    end
  end

  // pin decode
  wire logic strobing;
  assign strobing = (state_next == H_STROBE) || (state_next == H_RISE);

  logic reconfig_n_reg;
  logic ws_n_reg;
  logic rs_n_reg;
  logic cs_reg;
  logic ncs_reg;
  logic data_oe_n_reg;
  logic stat_oe_n_reg;
  pacl_byte_type data_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hy1_reg <= 4'hf;
      hy2_reg <= 4'hf;
      state_reg <= H_IDLE;
      cnt_reg <= '0;
      in_ready_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      hy1_reg <= hy_raw;
      hy2_reg <= hy1_reg;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      in_ready_reg <= (state_next == H_READY) && !done_seen;
      data_reg <= take ? in_data : data_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reconfig_n_reg <= 1'b1;
      ws_n_reg <= 1'b1;
      rs_n_reg <= 1'b1;
      cs_reg <= 1'b0;
      ncs_reg <= 1'b1;
      data_oe_n_reg <= 1'b1;
      stat_oe_n_reg <= 1'b1;
    end else begin
      reconfig_n_reg <= (state_next != H_PULSE);
      ws_n_reg <= (state_next != H_STROBE);
      rs_n_reg <= !(state_next == H_PACE && use_poll);
      cs_reg <= strobing;
      ncs_reg <= !strobing;
      data_oe_n_reg <= !strobing;
      stat_oe_n_reg <= !stretch_status;
    end
  end

  // user startup clock after done
  logic [`PACL_SMALL_W-1:0] cu_wait_reg;
  logic [`PACL_SMALL_W-1:0] div_reg;
  logic uclk_reg;
  wire logic uclk_en;
  wire logic div_end;
  assign uclk_en = use_user_clock && done_seen && cu_wait_reg == `PACL_SMALL_W'(`PACL_CD2CU_CYC);
  assign div_end = (div_reg == `PACL_SMALL_W'(`PACL_UCLK_HALF_CYC - 1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cu_wait_reg <= '0;
      div_reg <= '0;
      uclk_reg <= 1'b0;
    end else begin
      if (!done_seen) begin
        cu_wait_reg <= '0;
      end else if (!uclk_en) begin
        cu_wait_reg <= cu_wait_reg + 4'h1;
      end
      div_reg <= (!uclk_en || div_end) ? '0 : div_reg + 4'h1;
      uclk_reg <= (uclk_en && div_end) ? !uclk_reg : uclk_reg;
    end
  end

  // outputs
  assign link.reconfig_n = reconfig_n_reg;
  assign link.write_strobe_n = ws_n_reg;
  assign link.read_strobe_n = rs_n_reg;
  assign link.chip_select = cs_reg;
  assign link.select_low_active = ncs_reg;
  assign link.host_data_out = data_reg;
  assign link.host_data_oe_n = data_oe_n_reg;
  assign link.host_status_out = 1'b0;
  assign link.host_status_oe_n = stat_oe_n_reg;
  assign link.user_startup_clock = uclk_reg;
  assign cfg_done = hy2_reg[`PACL_HY_DONE];
  assign in_ready = in_ready_reg;
endmodule : pacl_host

/* File: pacl_link_asserts.sv */
`timescale 1ns/1ps
module pacl_link_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // host driven
  input wire logic reconfig_n,
  input wire logic select_low_active,
  input wire logic chip_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  // device driven and resolved
  input wire logic dev_status_oe_n,
  input wire logic dev_d7_oe_n,
  input wire logic done,
  input wire logic ready_busy_flag,
  input wire logic chain_enable_out_n,
  input wire logic status_n
);
  logic [16:0] st_low_reg;
  logic [16:0] since_rc_reg;
  logic seen_rc_reg;
  logic ws_prev_reg;
  wire logic ws_take;
  assign ws_take = write_strobe_n && !ws_prev_reg && chip_select && !select_low_active && status_n && !done;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // low-time and hold-off counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_low_reg <= 17'h0_0000;
      since_rc_reg <= 17'h0_0000;
      seen_rc_reg <= 1'b0;
      ws_prev_reg <= 1'b1;
    end else begin
      ws_prev_reg <= write_strobe_n;
      st_low_reg <= dev_status_oe_n ? 17'h0_0000 : st_low_reg + 17'h0_0001;
      since_rc_reg <= !reconfig_n ? 17'h0_0000 : (since_rc_reg < 17'h0_07d0 ? since_rc_reg + 17'h0_0001 : since_rc_reg);
      seen_rc_reg <= !reconfig_n || (seen_rc_reg && !dev_status_oe_n);
    end
  end
  property p_done_rise; $rose(done) |-> status_n && reconfig_n; endproperty
  a_done_rise: assert property (p_done_rise) else $error("done rose outside configuration");
  property p_reconf_pull; $fell(reconfig_n) |-> ##[1:8] (!done && !status_n); endproperty
  a_reconf_pull: assert property (p_reconf_pull) else $error("done or status not pulled low");
  property p_stat_min; $rose(dev_status_oe_n) && seen_rc_reg |-> st_low_reg >= 17'h0_0064; endproperty
  a_stat_min: assert property (p_stat_min) else $error("status low pulse too short");
  property p_stat_rel; $rose(reconfig_n) |-> ##[1:1000] dev_status_oe_n; endproperty
  a_stat_rel: assert property (p_stat_rel) else $error("status not released in time");
  property p_ws_wait; $rose(write_strobe_n) |-> since_rc_reg >= 17'h0_03e8; endproperty
  a_ws_wait: assert property (p_ws_wait) else $error("write strobe too soon after request");
  property p_busy; ws_take |-> ##[1:5] !ready_busy_flag; endproperty
  a_busy: assert property (p_busy) else $error("busy not shown after strobe");
  property p_d7_drive; $fell(read_strobe_n) && status_n && !done |-> ##[1:6] !dev_d7_oe_n; endproperty
  a_d7_drive: assert property (p_d7_drive) else $error("bit seven not driven on poll");
  property p_d7_quiet; done |-> dev_d7_oe_n; endproperty
  a_d7_quiet: assert property (p_d7_quiet) else $error("bit seven driven after done");
  property p_chain; $rose(done) |-> ##[0:2] !chain_enable_out_n; endproperty
  a_chain: assert property (p_chain) else $error("chain enable not lowered");
  c_byte: cover property (ws_take);
  c_reconf: cover property ($fell(reconfig_n));
  c_poll: cover property ($fell(dev_d7_oe_n));
  c_done: cover property ($rose(done));
endmodule : pacl_link_asserts

/* File: pacl_link_if.sv */
`timescale 1ns/1ps
interface pacl_link_if;
  import pacl_pkg::*;
  // host driven
  logic reconfig_n;
  logic select_low_active;
  logic chip_select;
  logic write_strobe_n;
  logic read_strobe_n;
  logic user_startup_clock;
  pacl_byte_type host_data_out;
  logic host_data_oe_n;
  logic host_status_out;
  logic host_status_oe_n;
  // device driven
  logic dev_status_out;
  logic dev_status_oe_n;
  logic dev_d7_out;
  logic dev_d7_oe_n;
  logic done;
  logic ready_busy_flag;
  logic chain_enable_out_n;
  // resolved wires, pulled high when nobody drives
  logic status_n;
  pacl_byte_type data;
  assign status_n = ~((~dev_status_oe_n & ~dev_status_out) | (~host_status_oe_n & ~host_status_out));
  assign data[6:0] = host_data_oe_n ? 7'h7f : host_data_out[6:0];
  assign data[7] = !host_data_oe_n ? host_data_out[7] : (!dev_d7_oe_n ? dev_d7_out : 1'b1);
  modport device (
    input reconfig_n, select_low_active, chip_select, write_strobe_n, read_strobe_n, user_startup_clock,
    input status_n, data,
    output dev_status_out, dev_status_oe_n, dev_d7_out, dev_d7_oe_n, done, ready_busy_flag, chain_enable_out_n
  );
  modport host (
    output reconfig_n, select_low_active, chip_select, write_strobe_n, read_strobe_n, user_startup_clock,
    output host_data_out, host_data_oe_n, host_status_out, host_status_oe_n,
    input status_n, data, done, ready_busy_flag, chain_enable_out_n
  );
endinterface : pacl_link_if

/* File: pacl_pkg.sv */
package pacl_pkg;
  typedef logic [7:0] pacl_byte_type;
  typedef enum logic [2:0] {DEV_POR, DEV_CLEAR, DEV_WAIT, DEV_CONFIG, DEV_STARTUP, DEV_USER} pacl_dev_state_type;
  typedef enum logic [2:0] {H_IDLE, H_PULSE, H_WAITST, H_HOLDOFF, H_READY, H_STROBE, H_RISE, H_PACE} pacl_host_state_type;
endpackage : pacl_pkg

/* File: parallel_async_config_port_tb.sv */
`timescale 1ns/1ps
`include "pacl_defines.svh"
module parallel_async_config_port_tb;
  import pacl_pkg::*;
  localparam int POR = 50;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic chain_enable_in_n = 1'b0;
  logic image_complete = 1'b0;
  logic use_user_clock = 1'b0;
  logic use_poll = 1'b0;
  logic stretch_status = 1'b0;
  logic cfg_start = 1'b0;
  logic in_valid = 1'b0;
  logic out_ready = 1'b0;
  logic stall_all = 1'b0;
  logic saw_d7 = 1'b0;
  pacl_byte_type in_data = 8'h00;
  pacl_byte_type out_data;
  logic user_mode, out_valid, cfg_done, in_ready;
  pacl_byte_type exp_q[$];
  integer seed = 46004;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t;
  pacl_link_if link ();
  pacl_device #(.POR_CYC(POR)) pacl_device_i (.clock(clock), .arst_n(arst_n), .link(link),
    .chain_enable_in_n(chain_enable_in_n), .image_complete(image_complete), .use_user_clock(use_user_clock),
    .user_mode(user_mode), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  pacl_host pacl_host_i (.clock(clock), .arst_n(arst_n), .link(link), .cfg_start(cfg_start), .use_poll(use_poll),
    .use_user_clock(use_user_clock), .stretch_status(stretch_status), .cfg_done(cfg_done),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready));
  pacl_link_asserts pacl_link_asserts_i (.clock(clock), .arst_n(arst_n), .reconfig_n(link.reconfig_n),
    .select_low_active(link.select_low_active), .chip_select(link.chip_select),
    .write_strobe_n(link.write_strobe_n), .read_strobe_n(link.read_strobe_n),
    .dev_status_oe_n(link.dev_status_oe_n), .dev_d7_oe_n(link.dev_d7_oe_n), .done(link.done),
    .ready_busy_flag(link.ready_busy_flag), .chain_enable_out_n(link.chain_enable_out_n), .status_n(link.status_n));
  always #50 clock = ~clock;
  task automatic fail(input string msg);
    $display("Error at %0t ns: %s", $time, msg);
    err_count = err_count + 1;
  endtask : fail
  task automatic check_bit(input logic got, input logic exp, input string msg);
    total_checks = total_checks + 1;
    if (got !== exp) fail(msg);
  endtask : check_bit
  task automatic check_byte(input pacl_byte_type got, input pacl_byte_type exp, input string msg);
    total_checks = total_checks + 1;
    if (got !== exp) fail(msg);
  endtask : check_byte
  task automatic check_span(input int got, input int lo, input int hi, input string msg);
    total_checks = total_checks + 1;
    if (got < lo || got > hi) fail(msg);
  endtask : check_span
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  function automatic int um_lo(input logic uclk);
    return uclk ? `PACL_USER_CLK_EDGES * 2 * `PACL_UCLK_HALF_CYC : 20 * 1000 / `PACL_CLK_NS - 1;
  endfunction : um_lo
  function automatic int um_hi(input logic uclk);
    return uclk ? um_lo(1'b1) + 40 : 40 * 1000 / `PACL_CLK_NS;
  endfunction : um_hi
  // timeout and receiver with random stalls
  always @(posedge clock) begin
    cyc = cyc + 1;
    out_ready <= !stall_all && ($random(seed) % 4 != 0);
    if (cyc == 40000) begin
      fail("run timed out");
      print_verdict();
    end
  end
  always @(negedge clock) begin
    if (link.dev_d7_oe_n === 1'b0) saw_d7 = 1'b1;
    if (out_valid === 1'b1 && out_ready) begin
      if (exp_q.size() == 0) fail("unexpected byte");
      else check_byte(out_data, exp_q.pop_front(), "received byte");
    end
  end
  task automatic send_byte(input pacl_byte_type b, input logic expect_rx);
    @(posedge clock);
    if (expect_rx) exp_q.push_back(b);
    in_valid <= 1'b1;
    in_data <= b;
    @(negedge clock);
    for (t = 0; t < (expect_rx ? 3000 : 100) && in_ready !== 1'b1; t++) @(negedge clock);
    if (expect_rx) check_bit(in_ready, 1'b1, "byte not taken");
    else check_bit(in_ready, 1'b0, "byte taken after done");
    @(posedge clock);
    in_valid <= 1'b0;
  endtask : send_byte
  task automatic drain();
    for (t = 0; t < 800 && exp_q.size() != 0; t++) @(negedge clock);
    check_bit(exp_q.size() == 0, 1'b1, "bytes not delivered");
    check_bit(link.done, 1'b0, "done high during configuration");
  endtask : drain
  task automatic run_cfg(input logic poll, input logic uclk, input int nbytes);
    @(posedge clock);
    use_poll <= poll;
    use_user_clock <= uclk;
    cfg_start <= 1'b1;
    // held until the host leaves pacing and answers
    for (t = 0; t < 50 && link.reconfig_n !== 1'b0; t++) @(negedge clock);
    @(posedge clock);
    cfg_start <= 1'b0;
    repeat (8) @(negedge clock);
    check_bit(link.done, 1'b0, "done not low");
    check_bit(link.status_n, 1'b0, "status not low");
    for (t = 0; t < 3000 && in_ready !== 1'b1; t++) @(negedge clock);
    check_bit(link.status_n, 1'b1, "status not released");
    for (int i = 0; i < nbytes; i++) send_byte(i == 0 ? 8'hff : (i == 1 ? 8'h00 : 8'($random(seed))), 1'b1);
    drain();
  endtask : run_cfg
  task automatic finish_cfg(input logic uclk);
    @(posedge clock);
    image_complete <= 1'b1;
    for (t = 0; t < 100 && link.done !== 1'b1; t++) @(negedge clock);
    @(posedge clock);
    image_complete <= 1'b0;
    for (t = 1; t < 3000 && user_mode !== 1'b1; t++) @(negedge clock);
    check_span(t, um_lo(uclk), um_hi(uclk), "startup length");
    check_bit(link.chain_enable_out_n, 1'b0, "chain enable high");
    check_bit(link.status_n & link.reconfig_n & link.done, 1'b1, "user mode levels");
    check_bit(link.ready_busy_flag, 1'b1, "busy in user mode");
    check_bit(cfg_done, 1'b1, "host missed done");
    send_byte(8'h5a, 1'b0);
    repeat (10) @(negedge clock);
  endtask : finish_cfg
  task automatic power_on();
    @(negedge clock);
    check_bit(link.status_n, 1'b0, "status high after reset");
    check_bit(link.done, 1'b0, "done high after reset");
    for (t = 1; t < POR + 20 && link.status_n !== 1'b1; t++) @(negedge clock);
    check_span(t, POR, POR + 10, "power-on hold");
  endtask : power_on
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    power_on();
    $display("test power_on finished");
    run_cfg(1'b0, 1'b0, 6);
    finish_cfg(1'b0);
    $display("test handshake_internal finished");
    run_cfg(1'b1, 1'b1, 5);
    check_bit(saw_d7, 1'b1, "bit seven never driven");
    finish_cfg(1'b1);
    $display("test poll_user_clock finished");
    run_cfg(1'b0, 1'b0, 3);
    run_cfg(1'b1, 1'b0, 4);
    finish_cfg(1'b0);
    $display("test abort_restart finished");
    @(posedge clock);
    stretch_status <= 1'b1;
    fork
      run_cfg(1'b0, 1'b0, 2);
      begin
        repeat (300) @(negedge clock);
        check_bit(link.status_n, 1'b0, "stretch ignored");
        check_bit(in_ready, 1'b0, "ready while status low");
        @(posedge clock);
        stretch_status <= 1'b0;
      end
    join
    finish_cfg(1'b0);
    $display("test status_stretch finished");
    run_cfg(1'b0, 1'b0, 0);
    @(posedge clock);
    stall_all <= 1'b1;
    fork
      for (int i = 0; i < 5; i++) send_byte(8'($random(seed)), 1'b1);
      begin
        repeat (400) @(negedge clock);
        check_bit(out_valid, 1'b1, "buffer empty while stalled");
        check_bit(link.ready_busy_flag, 1'b0, "ready while buffer full");
        check_bit(in_ready, 1'b0, "host took byte while busy");
        @(posedge clock);
        stall_all <= 1'b0;
      end
    join
    drain();
    finish_cfg(1'b0);
    $display("test buffer_full finished");
    run_cfg(1'b0, 1'b0, 2);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    power_on();
    run_cfg(1'b0, 1'b0, 2);
    finish_cfg(1'b0);
    $display("test mid_reset finished");
    print_verdict();
  end
endmodule : parallel_async_config_port_tb
